// [hw/ioc_pkg.sv]
`default_nettype none
package ioc_pkg;
  // ---------------------------------------------------------------
  // group and calibration geometry
  // ---------------------------------------------------------------
  localparam int GROUP_CELLS = 14;     // cells per strobe group
  localparam int BUS_CELLS = 13;       // cells fed by the strobe bus
  localparam int BITS_PER_STROBE = 8;  // read data bits per strobe
  localparam int CAL_W = 6;            // calibration bus width
  localparam int DLY_DEPTH = 64;       // taps reachable by a CAL_W code
  localparam int SYNC_STAGES = 2;      // pin synchroniser depth

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic TS_RST = 1'b0;      // stored enable: pad not driven
  localparam logic OE_RST = 1'b0;      // pad enable out of reset
  localparam logic LVL_RST = 1'b0;     // sampled clock and strobe levels

  // tristate storage configuration
  typedef enum logic [1:0] {
    IOC_SDR_FF,
    IOC_SDR_LATCH,
    IOC_DDR
  } ioc_mode_t;

  // optional polarity inversion used on clock, enable and reset
  function automatic logic apply_inv(input logic x, input logic inv);
    apply_inv = x ^ inv;
  endfunction : apply_inv
endpackage : ioc_pkg
`default_nettype wire

// [hw/ioc_strobe_delay.sv]
`timescale 1ns/1ps
`default_nettype none
module ioc_strobe_delay #(
  parameter int CAL_W = ioc_pkg::CAL_W,
  parameter int DEPTH = ioc_pkg::DLY_DEPTH
) (
  input wire logic mclk,             // system clock
  input wire logic rst_n,            // async reset, active low
  input wire logic strobe_in,        // synchronised strobe level
  input wire logic [CAL_W-1:0] code, // calibration code, taps minus one
  output logic strobe_out            // delayed strobe level
);
  // ---------------------------------------------------------------
  // tapped delay line
  // ---------------------------------------------------------------
  logic [DEPTH-1:0] tap_q;
  logic [DEPTH-1:0] tap_d;
  logic out_d;

  // shift one tap a cycle; the code picks the tap and the output is registered, so delay is code+2
  always_comb begin
    tap_d = {tap_q[DEPTH-2:0], strobe_in};
    out_d = tap_q[code];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= '0;
      strobe_out <= ioc_pkg::LVL_RST;
    end else begin
      tap_q <= tap_d;
      strobe_out <= out_d;
    end
  end
endmodule : ioc_strobe_delay
`default_nettype wire

// [hw/ioc_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module ioc_cell #(
  parameter int DW = ioc_pkg::BITS_PER_STROBE,
  parameter int BUS_N = ioc_pkg::BUS_CELLS,
  parameter bit RIGHT_HALF = 1'b0,   // which DLL serves this group
  parameter bit EDGE_CELL = 1'b1     // cell sits on a left or right edge
) (
  input wire logic mclk,                         // system clock, 100 MHz
  input wire logic rst_n,                        // async reset, active low
  input wire logic supply_ok_pin,                // supply good, async
  input wire logic route_clk,                    // routing clock, async
  input wire logic strobe_pin,                   // memory read strobe, async
  input wire logic [DW-1:0] rd_data_pin,         // memory read data, async
  input wire logic clk_sel,                      // 1 = strobe, 0 = routing clock
  input wire logic clk_inv,                      // invert cell clock
  input wire logic ce_in,                        // clock enable from routing
  input wire logic ce_inv,                       // invert clock enable
  input wire logic lsr_in,                       // local reset from routing
  input wire logic lsr_inv,                      // invert local reset
  input wire logic gts,                          // global tristate, 1 = pad not driven
  input wire ioc_pkg::ioc_mode_t ts_mode,        // tristate storage mode
  input wire logic tristate_enable_first,        // enable, first half
  input wire logic tristate_enable_second,       // enable, second half
  input wire logic [ioc_pkg::CAL_W-1:0] dll_code_left,  // left DLL code
  input wire logic [ioc_pkg::CAL_W-1:0] dll_code_right, // right DLL code
  input wire logic pair_en,                      // join with neighbour
  input wire logic lvds_req,                     // ask for LVDS on the pair
  input wire logic pad_dout,                     // data to drive on the pad
  output logic pad_oe,                           // pad driver enable
  output logic pad_t_o,                          // true pad data
  output logic pad_c_o,                          // complement pad data
  output logic lvds_on,                          // pair runs as LVDS
  output logic [BUS_N-1:0] strobe_bus,           // delayed strobe to group
  output logic strobe_pol,                       // sync register polarity
  output logic [DW-1:0] rd_pos,                  // data taken on strobe rise
  output logic [DW-1:0] rd_neg,                  // data taken on strobe fall
  output logic [DW-1:0] rd_sync_pos,             // rise data in cell domain
  output logic [DW-1:0] rd_sync_neg              // fall data in cell domain
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [DW+2:0] sync1_q;
  logic [DW+2:0] sync2_q;
  logic supply_s;
  logic route_s;
  logic strobe_s;
  logic [DW-1:0] rd_s;

  // first stage is read only by the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {supply_ok_pin, route_clk, strobe_pin, rd_data_pin};
      sync2_q <= sync1_q;
    end
  end

  assign {supply_s, route_s, strobe_s, rd_s} = sync2_q;

  // ---------------------------------------------------------------
  // strobe delay and bus
  // ---------------------------------------------------------------
  logic [ioc_pkg::CAL_W-1:0] cal_code;
  logic dly_strobe;

  // each group listens only to the DLL of its own half
  assign cal_code = RIGHT_HALF ? dll_code_right : dll_code_left;

  ioc_strobe_delay #(
    .CAL_W(ioc_pkg::CAL_W),
    .DEPTH(ioc_pkg::DLY_DEPTH)
  ) u_dly (
    .mclk(mclk),
    .rst_n(rst_n),
    .strobe_in(strobe_s),
    .code(cal_code),
    .strobe_out(dly_strobe)
  );

  // one delayed strobe fans out to the rest of the group
  assign strobe_bus = {BUS_N{dly_strobe}};

  // ---------------------------------------------------------------
  // control selection
  // ---------------------------------------------------------------
  logic cclk;
  logic ce;
  logic lsr;
  logic cclk_q;
  logic sb_q;
  logic c_rise;
  logic c_fall;
  logic sb_rise;
  logic sb_fall;

  // the strobe choice uses the delayed copy so it lines up with read data
  assign cclk = ioc_pkg::apply_inv(clk_sel ? dly_strobe : route_s, clk_inv);
  assign ce = ioc_pkg::apply_inv(ce_in, ce_inv);
  assign lsr = ioc_pkg::apply_inv(lsr_in, lsr_inv);
  assign c_rise = cclk & ~cclk_q;
  assign c_fall = ~cclk & cclk_q;
  assign sb_rise = dly_strobe & ~sb_q;
  assign sb_fall = ~dly_strobe & sb_q;

  // ---------------------------------------------------------------
  // tristate storage
  // ---------------------------------------------------------------
  logic first_q;
  logic first_d;
  logic second_q;
  logic second_d;
  logic oe_sel;
  logic oe_d;

  // latches are modelled as sampled followers, one cycle behind the gate
  always_comb begin
    first_d = first_q;
    second_d = second_q;
    if (lsr) begin
      first_d = ioc_pkg::TS_RST;
      second_d = ioc_pkg::TS_RST;
    end else if (ce) begin
      case (ts_mode)
        ioc_pkg::IOC_SDR_FF: begin
          if (c_rise) first_d = tristate_enable_first;
        end
        ioc_pkg::IOC_SDR_LATCH: begin
          if (!cclk) first_d = tristate_enable_first;
        end
        ioc_pkg::IOC_DDR: begin
          if (c_rise) first_d = tristate_enable_first;
          if (!cclk) second_d = tristate_enable_second;
        end
        default: begin
          first_d = ioc_pkg::TS_RST;
          second_d = ioc_pkg::TS_RST;
        end
      endcase
    end
  end

  // high half shows the held latch, low half the edge register
  always_comb begin
    oe_sel = (ts_mode == ioc_pkg::IOC_DDR && cclk) ? second_q : first_q;
    oe_d = oe_sel & ~gts & supply_s;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= ioc_pkg::TS_RST;
      second_q <= ioc_pkg::TS_RST;
      cclk_q <= ioc_pkg::LVL_RST;
      sb_q <= ioc_pkg::LVL_RST;
      pad_oe <= ioc_pkg::OE_RST;
    end else begin
      first_q <= first_d;
      second_q <= second_d;
      cclk_q <= cclk;
      sb_q <= dly_strobe;
      pad_oe <= oe_d;
    end
  end

  // ---------------------------------------------------------------
  // pad data and pairing
  // ---------------------------------------------------------------
  logic t_d;
  logic c_d;
  logic lvds_d;

  // a lone cell leaves the complement low; LVDS is refused off the edges
  always_comb begin
    t_d = pad_dout;
    c_d = pair_en ? ~pad_dout : 1'b0;
    lvds_d = pair_en & lvds_req & EDGE_CELL;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_t_o <= 1'b0;
      pad_c_o <= 1'b0;
      lvds_on <= 1'b0;
    end else begin
      pad_t_o <= t_d;
      pad_c_o <= c_d;
      lvds_on <= lvds_d;
    end
  end

  // ---------------------------------------------------------------
  // read capture and polarity
  // ---------------------------------------------------------------
  logic [DW-1:0] pos_d;
  logic [DW-1:0] neg_d;
  logic [DW-1:0] spos_d;
  logic [DW-1:0] sneg_d;
  logic pol_d;
  logic xfer;

  // polarity picks the cell clock edge that moves data to the sync stage
  always_comb begin
    pos_d = sb_rise ? rd_s : rd_pos;
    neg_d = sb_fall ? rd_s : rd_neg;
    pol_d = c_rise ? dly_strobe : strobe_pol;
    xfer = strobe_pol ? c_fall : c_rise;
    spos_d = xfer ? rd_pos : rd_sync_pos;
    sneg_d = xfer ? rd_neg : rd_sync_neg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pos <= '0;
      rd_neg <= '0;
      strobe_pol <= 1'b0;
      rd_sync_pos <= '0;
      rd_sync_neg <= '0;
    end else begin
      rd_pos <= pos_d;
      rd_neg <= neg_d;
      strobe_pol <= pol_d;
      rd_sync_pos <= spos_d;
      rd_sync_neg <= sneg_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_pwr_hiz;
    @(posedge mclk) disable iff (!rst_n) !supply_s |=> !pad_oe;
  endproperty
  a_pwr_hiz: assert property (p_pwr_hiz) else $error("pad driven without supply");

  property p_gts;
    @(posedge mclk) disable iff (!rst_n) gts |=> !pad_oe;
  endproperty
  a_gts: assert property (p_gts) else $error("pad driven under global tristate");

  property p_lsr;
    @(posedge mclk) disable iff (!rst_n) lsr |=> (!first_q && !second_q)[*1] ##1 !pad_oe;
  endproperty
  a_lsr: assert property (p_lsr) else $error("local reset left storage driving");

  property p_ff_take;
    @(posedge mclk) disable iff (!rst_n)
      (ts_mode == ioc_pkg::IOC_SDR_FF && c_rise && ce && !lsr)
      |=> first_q == $past(tristate_enable_first);
  endproperty
  a_ff_take: assert property (p_ff_take) else $error("flip-flop missed its edge");

  property p_ff_hold;
    @(posedge mclk) disable iff (!rst_n)
      (ts_mode != ioc_pkg::IOC_SDR_LATCH && !c_rise && !lsr) |=> $stable(first_q);
  endproperty
  a_ff_hold: assert property (p_ff_hold) else $error("edge register changed off edge");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_n)
      (ts_mode == ioc_pkg::IOC_DDR && cclk && !lsr) |=> $stable(second_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch open while gate high");

  property p_ddr_mux;
    @(posedge mclk) disable iff (!rst_n)
      (ts_mode == ioc_pkg::IOC_DDR && supply_s && !gts)
      |=> pad_oe == $past(cclk ? second_q : first_q);
  endproperty
  a_ddr_mux: assert property (p_ddr_mux) else $error("wrong half on pad enable");

  property p_rd_rise;
    @(posedge mclk) disable iff (!rst_n) sb_rise |=> rd_pos == $past(rd_s);
  endproperty
  a_rd_rise: assert property (p_rd_rise) else $error("read data not taken on strobe");

  property p_lvds_edge;
    @(posedge mclk) disable iff (!rst_n) (!pair_en || !EDGE_CELL) |=> !lvds_on;
  endproperty
  a_lvds_edge: assert property (p_lvds_edge) else $error("lvds outside an edge pair");

  c_ddr_high: cover property (@(posedge mclk) disable iff (!rst_n)
    ts_mode == ioc_pkg::IOC_DDR && cclk && pad_oe);
  c_lsr: cover property (@(posedge mclk) disable iff (!rst_n) lsr ##1 !first_q);
  c_strobe: cover property (@(posedge mclk) disable iff (!rst_n) sb_rise ##[1:20] sb_fall);
endmodule : ioc_cell
`default_nettype wire

// [verif/ioc_ddr_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// read side of a ddr memory: strobe and data launched together
// ---------------------------------------------------------------
module ioc_ddr_mem_model (
  output var logic strobe_pin,       // read strobe, still between frames
  output var logic [7:0] rd_data_pin // read data, one byte per strobe
);
  initial begin
    strobe_pin = 1'b0;
    rd_data_pin = 8'h00;
  end

  // each byte rides on one strobe toggle; the cell delays the strobe
  task automatic burst(input logic [7:0] base, input int beats, input int pre,
                       input realtime half);
    #(pre);
    for (int i = 0; i < beats; i++) begin
      rd_data_pin = base + 8'(i);
      strobe_pin = ~strobe_pin;
      #(half);
    end
    // released bus: no stale byte, so a late capture shows up
    rd_data_pin = ~rd_data_pin;
  endtask : burst
endmodule : ioc_ddr_mem_model
`default_nettype wire

// [verif/io_cell_ddr_tristate_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module io_cell_ddr_tristate_control_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok_pin = 1'b0;
  logic route_clk = 1'b0;
  logic strobe_pin;
  logic [7:0] rd_data_pin;
  logic clk_sel = 1'b0;
  logic clk_inv = 1'b0;
  logic ce_in = 1'b1;
  logic ce_inv = 1'b0;
  logic lsr_in = 1'b0;
  logic lsr_inv = 1'b0;
  logic gts = 1'b0;
  logic pair_en = 1'b0;
  logic lvds_req = 1'b0;
  logic pad_dout = 1'b0;
  logic tristate_enable_first = 1'b0;
  logic tristate_enable_second = 1'b0;
  ioc_pkg::ioc_mode_t ts_mode = ioc_pkg::IOC_SDR_FF;
  logic [ioc_pkg::CAL_W-1:0] dll_code_left = 6'h01;
  logic [ioc_pkg::CAL_W-1:0] dll_code_right = 6'h3f; // wrong half would miss the eye
  logic pad_oe, pad_t_o, pad_c_o, lvds_on, strobe_pol;
  logic [12:0] strobe_bus;
  logic [7:0] rd_pos, rd_neg, rd_sync_pos, rd_sync_neg;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  ioc_cell dut (.mclk, .rst_n, .supply_ok_pin, .route_clk, .strobe_pin, .rd_data_pin,
    .clk_sel, .clk_inv, .ce_in, .ce_inv, .lsr_in, .lsr_inv, .gts, .ts_mode,
    .tristate_enable_first, .tristate_enable_second, .dll_code_left, .dll_code_right,
    .pair_en, .lvds_req, .pad_dout, .pad_oe, .pad_t_o, .pad_c_o, .lvds_on, .strobe_bus,
    .strobe_pol, .rd_pos, .rd_neg, .rd_sync_pos, .rd_sync_neg);
  ioc_ddr_mem_model mem (.strobe_pin, .rd_data_pin);

  always #5 mclk = ~mclk;

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  // routing clock moves slowly so the synchroniser and edge finder settle
  task automatic edge_r(input logic v);
    route_clk = v;
    step(8);
  endtask : edge_r

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // byte taken on an edge: last byte if the final level matches that edge
  function automatic logic [7:0] exp_rd(input logic [7:0] base, input int n, input logic lvl,
                                        input logic rise);
    return (lvl == rise) ? base + 8'(n - 1) : base + 8'(n - 2);
  endfunction : exp_rd

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] b;
    logic e;
    logic q;
    logic lvl;
    void'($urandom(63259));
    step(10);
    rst_n = 1'b1;
    step(1);
    chk_bit("pad_oe reset", 1'b0, pad_oe);
    chk_vec("strobe_bus reset", 13'h0000, strobe_bus);
    tristate_enable_first = 1'b1;
    edge_r(1'b1);
    chk_bit("pad_oe supply low", 1'b0, pad_oe);
    supply_ok_pin = 1'b1;
    edge_r(1'b0);
    edge_r(1'b1);
    chk_bit("pad_oe supply good", 1'b1, pad_oe);
    done("power");
    // cell clock is high here; flipping the inversion only ever makes a fall
    q = 1'b1;
    for (int i = 0; i < 16; i++) begin
      clk_inv = 1'($urandom());
      ce_in = 1'($urandom());
      ce_inv = 1'($urandom());
      edge_r(clk_inv);
      e = 1'($urandom());
      tristate_enable_first = e;
      step(6);
      chk_bit("pad_oe ff hold", q, pad_oe);
      edge_r(~clk_inv);
      if (ce_in ^ ce_inv) q = e;
      chk_bit("pad_oe ff", q, pad_oe);
    end
    done("sdr flip-flop");
    ts_mode = ioc_pkg::IOC_SDR_LATCH;
    ce_in = 1'b1;
    ce_inv = 1'b0;
    for (int i = 0; i < 8; i++) begin
      e = 1'($urandom());
      tristate_enable_first = e;
      edge_r(clk_inv);
      chk_bit("pad_oe latch open", e, pad_oe);
      edge_r(~clk_inv);
      tristate_enable_first = ~e;
      step(8);
      chk_bit("pad_oe latch held", e, pad_oe);
    end
    done("sdr latch");
    ts_mode = ioc_pkg::IOC_DDR;
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom());
      tristate_enable_second = b[1];
      edge_r(clk_inv);
      tristate_enable_first = b[0];
      step(4);
      edge_r(~clk_inv);
      chk_bit("pad_oe ddr high half", b[1], pad_oe);
      tristate_enable_second = ~b[1];
      tristate_enable_first = ~b[0];
      step(6);
      chk_bit("pad_oe ddr latch held", b[1], pad_oe);
      edge_r(clk_inv);
      chk_bit("pad_oe ddr low half", b[0], pad_oe);
    end
    done("ddr");
    for (int i = 0; i < 2; i++) begin
      lsr_inv = 1'(i);
      lsr_in = 1'(i);
      tristate_enable_first = 1'b1;
      tristate_enable_second = 1'b1;
      edge_r(clk_inv);
      edge_r(~clk_inv);
      chk_bit("pad_oe driven", 1'b1, pad_oe);
      gts = 1'b1;
      step(4);
      chk_bit("pad_oe global tristate", 1'b0, pad_oe);
      gts = 1'b0;
      lsr_in = ~lsr_in;
      step(6);
      chk_bit("pad_oe local reset", 1'b0, pad_oe);
      lsr_in = ~lsr_in;
      step(6);
      chk_bit("pad_oe after local reset", 1'b0, pad_oe);
    end
    done("reset and tristate");
    for (int i = 0; i < 8; i++) begin
      pair_en = 1'(i);
      lvds_req = 1'(i >> 1);
      pad_dout = 1'($urandom());
      step(4);
      chk_bit("pad_t_o", pad_dout, pad_t_o);
      chk_bit("pad_c_o", pair_en & ~pad_dout, pad_c_o);
      chk_bit("lvds_on", pair_en & lvds_req, lvds_on);
    end
    done("pairing");
    // strobe as cell clock: starts low, so switching over is a fall
    clk_sel = 1'b1;
    clk_inv = 1'b0;
    ts_mode = ioc_pkg::IOC_SDR_FF;
    // only a strobe rise can load this, but the local reset already cleared it, so a stuck clock select also leaves the pad off
    tristate_enable_first = 1'b0;
    lvl = 1'b0;
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom());
      dll_code_left = 6'(i % 2); // short codes keep capture inside the data eye
      mem.burst(b, 3 + i, 7 + 11 * i, 62.5); // 125 ns strobe period
      lvl = lvl ^ 1'(3 + i);
      step(8);
      chk_vec("rd_pos", 13'(exp_rd(b, 3 + i, lvl, 1'b1)), 13'(rd_pos));
      chk_vec("rd_neg", 13'(exp_rd(b, 3 + i, lvl, 1'b0)), 13'(rd_neg));
      chk_vec("strobe_bus", {13{lvl}}, strobe_bus);
      chk_bit("strobe_pol", 1'b1, strobe_pol);
      // ending low, the last fall moved the newest rise byte and the fall byte before it
      if (!lvl) begin
        chk_vec("rd_sync_pos", 13'(exp_rd(b, 3 + i, lvl, 1'b1)), 13'(rd_sync_pos));
        chk_vec("rd_sync_neg", 13'(exp_rd(b, 2 + i, lvl, 1'b1)), 13'(rd_sync_neg));
      end
    end
    chk_bit("pad_oe strobe clock", 1'b0, pad_oe);
    done("strobe");
    summarize();
  end
endmodule : io_cell_ddr_tristate_control_tb
`default_nettype wire
